/* File: rtl/ttc_unit.sv */
// three timer/counter unit with special-function register access
// Notes on behaviour
// RULE1: mode 0 counts 13 bits: low five bits of low byte, all of high.
// RULE2: counts only when gate is 0, or gate 1 with its interrupt input high.
// RULE3: 13-bit wrap sets overflow flag and pulses wrap output one clock.
// RULE4: upper three low-byte bits in mode 0 are don't care.
// RULE5: mode 1 counts all 16 bits and wraps to zero.
// RULE6: mode 2 low byte counts, reloads from high byte on overflow.
// RULE7: mode 3 splits timer 0 into two bytes; timer 1 holds.
// RULE8: split low byte uses timer 0 controls and sets timer 0 flag.
// RULE9: split high byte counts prescaled clocks, timer 1 run and flag.
// RULE10: with timer 0 split, timer 1 runs in modes 0-2, stops in 3.
// RULE11: prescale bits 5,4,3 for timers 2,1,0: 1 gives /4, 0 gives /12.
// RULE12: prescale select ignored in external counter mode.
// RULE13: counter mode increments on falling edge of count input.
// RULE14: timer 2 counts internal clock only, no input or output pin.
// RULE15: timer 2 overflow sets its flag only when both clock selects are 0.
// RULE16: software writing 1 to timer 2 flags raises timer 2 interrupt.
// RULE17: serial clocks pick timer 2 when select set, else timer 1.
// RULE18: timer 2 mode from run, reload disable and clock selects.
// RULE19: baud generator mode counts every 2 clocks.
// RULE20: other timer 2 modes count every 4 or 12 clocks.
// RULE21: software writes 0 to timer 2 control bits 3 and 1.
// RULE22: reload disable 0 loads the reload pair on timer 2 overflow.
// RULE23: baud overflow pulses shift clock, reloads, leaves flag alone.
// RULE24: mode bits 00,01,10,11 select modes 0,1,2,3.
// RULE25: timer 0/1 flags clear on entry to their service routine.
// RULE26: gate 1 needs run and peripheral interrupt high; gate 0 run only.
// RULE27: reset clears counts, reloads, run bits, flags and modes.
`timescale 1ns/100ps
`default_nettype none
module ttc_unit
   import ttc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire ttc_sfr_req_t sfr_req_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic t_zero_count_input_i,
   input wire logic t_one_count_input_i,
   input wire logic ext_irq_zero_input_n_i,
   input wire logic ext_irq_one_input_n_i,
   input wire logic t_zero_isr_ack_i,
   input wire logic t_one_isr_ack_i,
   output logic t_zero_wrap_output_o,
   output logic t_one_wrap_output_o,
   output logic t_zero_irq_o,
   output logic t_one_irq_o,
   output logic t_two_irq_o,
   output logic rx_shift_clock_o,
   output logic tx_shift_clock_o
);
   logic [7:0] tctrl_q, tmode_q, ps_q, t2ctrl_q;
   logic [7:0] t0l_q, t0h_q, t1l_q, t1h_q, t2l_q, t2h_q, t2rll_q, t2rlh_q;
   logic [3:0] div0_q, div1_q, div2_q;
   logic cin0_q, cin1_q;
   logic tick0, tick1, tick2, tickh;
   logic en0, en1, enh;
   logic wr_tctrl, wr_t0l, wr_t0h, wr_t1l, wr_t1h, wr_t2c, wr_t2l, wr_t2h;
   logic ovf0, ovf1, ovfh, ovf2;
   logic [7:0] t0l_d, t0h_d, t1l_d, t1h_d;
   logic [15:0] t2_sum;
   logic baud_ovf;
   ttc_mode_t m0, m1;
   ttc_t2_mode_t t2m;

   // divider limit from prescale bit
   function automatic logic [3:0] div_lim(input logic fast);
      div_lim = fast ? TTC_DIV_FAST : TTC_DIV_SLOW; // see RULE11
   endfunction

   // divider step: back to zero when the next count reaches the limit
   function automatic logic [3:0] div_step(input logic [3:0] cnt, input logic [3:0] lim);
      div_step = (cnt + 4'h1 >= lim) ? 4'h0 : cnt + 4'h1;
   endfunction

   // write strobe for one register offset
   function automatic logic wr_hit(input ttc_sfr_req_t r, input logic [7:0] ofs);
      wr_hit = r.wr && (r.addr == ofs);
   endfunction

   assign wr_tctrl = wr_hit(sfr_req_i, TTC_OFS_TCTRL);
   assign wr_t0l = wr_hit(sfr_req_i, TTC_OFS_T0L);
   assign wr_t0h = wr_hit(sfr_req_i, TTC_OFS_T0H);
   assign wr_t1l = wr_hit(sfr_req_i, TTC_OFS_T1L);
   assign wr_t1h = wr_hit(sfr_req_i, TTC_OFS_T1H);
   assign wr_t2c = wr_hit(sfr_req_i, TTC_OFS_T2CTRL);
   assign wr_t2l = wr_hit(sfr_req_i, TTC_OFS_T2L);
   assign wr_t2h = wr_hit(sfr_req_i, TTC_OFS_T2H);

   // timer 0/1 mode fields
   assign m0 = ttc_mode_t'(tmode_q[TTC_MD_T0_BASE +: 2]); // see RULE24
   assign m1 = ttc_mode_t'(tmode_q[TTC_MD_T1_BASE +: 2]);

   // timer 2 mode decode
   always_comb begin
      if (!t2ctrl_q[TTC_T2_RUN]) begin
         t2m = TTC_T2_OFF; // see RULE18
      end else if (t2ctrl_q[TTC_T2_RXSEL] || t2ctrl_q[TTC_T2_TXSEL]) begin
         t2m = TTC_T2_BAUD;
      end else if (t2ctrl_q[TTC_T2_RLDIS]) begin
         t2m = TTC_T2_FREE;
      end else begin
         t2m = TTC_T2_RELOAD;
      end
   end

   // count inputs sampled for falling edges
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cin0_q <= 1'b1;
         cin1_q <= 1'b1;
      end else begin
         cin0_q <= t_zero_count_input_i;
         cin1_q <= t_one_count_input_i;
      end
   end

   // free-running prescale dividers, one per timer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         div0_q <= 4'h0;
         div1_q <= 4'h0;
         div2_q <= 4'h0;
      end else begin
         div0_q <= div_step(div0_q, div_lim(ps_q[TTC_PS_T0]));
         div1_q <= div_step(div1_q, div_lim(ps_q[TTC_PS_T1]));
         if (t2m == TTC_T2_BAUD) begin
            div2_q <= div_step(div2_q, TTC_DIV_BAUD); // see RULE19
         end else begin
            div2_q <= div_step(div2_q, div_lim(ps_q[TTC_PS_T2])); // see RULE20
         end
      end
   end

   // tick sources: counter mode uses edges and ignores prescale
   assign tick0 = tmode_q[TTC_MD_T0_BASE + TTC_MD_CNT]
      ? (cin0_q && !t_zero_count_input_i) : (div0_q == 4'h0); // see RULE12 see RULE13
   assign tick1 = tmode_q[TTC_MD_T1_BASE + TTC_MD_CNT]
      ? (cin1_q && !t_one_count_input_i) : (div1_q == 4'h0); // see RULE13
   assign tickh = (div0_q == 4'h0); // see RULE9
   assign tick2 = (div2_q == 4'h0); // see RULE14

   // gating: run bit, and interrupt input high when gate set
   assign en0 = tctrl_q[TTC_TC_T0_RUN] && tick0 // see RULE2 see RULE26
      && (!tmode_q[TTC_MD_T0_BASE + TTC_MD_GATE] || ext_irq_zero_input_n_i);
   assign en1 = (m0 == TTC_MSPLIT ? 1'b1 : tctrl_q[TTC_TC_T1_RUN]) && tick1
      && (m1 != TTC_MSPLIT) // see RULE7 see RULE10
      && (!tmode_q[TTC_MD_T1_BASE + TTC_MD_GATE] || ext_irq_one_input_n_i);
   assign enh = (m0 == TTC_MSPLIT) && tctrl_q[TTC_TC_T1_RUN] && tickh; // see RULE9

   // timer 0 next value and overflow
   always_comb begin
      t0l_d = t0l_q;
      t0h_d = t0h_q;
      ovf0 = 1'b0;
      ovfh = 1'b0;
      if (en0) begin
         case (m0)
            TTC_M13: begin
               {t0h_d, t0l_d[4:0]} = {t0h_q, t0l_q[4:0]} + 13'h0001; // see RULE1 see RULE4
               ovf0 = ({t0h_q, t0l_q[4:0]} == 13'h1FFF); // see RULE3
            end
            TTC_M16: begin
               {t0h_d, t0l_d} = {t0h_q, t0l_q} + 16'h0001; // see RULE5
               ovf0 = ({t0h_q, t0l_q} == 16'hFFFF);
            end
            TTC_M8R: begin
               ovf0 = (t0l_q == 8'hFF);
               t0l_d = ovf0 ? t0h_q : t0l_q + 8'h01; // see RULE6
            end
            default: begin
               t0l_d = t0l_q + 8'h01; // see RULE8
               ovf0 = (t0l_q == 8'hFF);
            end
         endcase
      end
      if (enh) begin
         t0h_d = t0h_q + 8'h01; // see RULE9
         ovfh = (t0h_q == 8'hFF);
      end
   end

   // timer 1 next value and overflow
   always_comb begin
      t1l_d = t1l_q;
      t1h_d = t1h_q;
      ovf1 = 1'b0;
      if (en1) begin
         case (m1)
            TTC_M13: begin
               {t1h_d, t1l_d[4:0]} = {t1h_q, t1l_q[4:0]} + 13'h0001; // see RULE1
               ovf1 = ({t1h_q, t1l_q[4:0]} == 13'h1FFF);
            end
            TTC_M16: begin
               {t1h_d, t1l_d} = {t1h_q, t1l_q} + 16'h0001; // see RULE5
               ovf1 = ({t1h_q, t1l_q} == 16'hFFFF);
            end
            TTC_M8R: begin
               ovf1 = (t1l_q == 8'hFF);
               t1l_d = ovf1 ? t1h_q : t1l_q + 8'h01; // see RULE6
            end
            default: begin
               t1l_d = t1l_q; // see RULE7
            end
         endcase
      end
   end

   // timer 0/1 count bytes: software write wins over counting
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         t0l_q <= TTC_RST_BYTE; // see RULE27
         t0h_q <= TTC_RST_BYTE;
         t1l_q <= TTC_RST_BYTE;
         t1h_q <= TTC_RST_BYTE;
      end else begin
         t0l_q <= wr_t0l ? sfr_req_i.wdata : t0l_d;
         t0h_q <= wr_t0h ? sfr_req_i.wdata : t0h_d;
         t1l_q <= wr_t1l ? sfr_req_i.wdata : t1l_d;
         t1h_q <= wr_t1h ? sfr_req_i.wdata : t1h_d;
      end
   end

   // timer control: flags set by overflow win over clears
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tctrl_q <= TTC_RST_BYTE;
      end else begin
         if (wr_tctrl) begin
            tctrl_q <= sfr_req_i.wdata;
         end
         if (t_zero_isr_ack_i) begin
            tctrl_q[TTC_TC_T0_FLAG] <= 1'b0; // see RULE25
         end
         if (t_one_isr_ack_i) begin
            tctrl_q[TTC_TC_T1_FLAG] <= 1'b0; // see RULE25
         end
         if (ovf0) begin
            tctrl_q[TTC_TC_T0_FLAG] <= 1'b1; // see RULE3 see RULE8
         end
         if (m0 == TTC_MSPLIT ? ovfh : ovf1) begin
            tctrl_q[TTC_TC_T1_FLAG] <= 1'b1; // see RULE9
         end
      end
   end

   // mode and prescale registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tmode_q <= TTC_RST_BYTE;
         ps_q <= TTC_RST_BYTE;
      end else begin
         if (wr_hit(sfr_req_i, TTC_OFS_TMODE)) begin
            tmode_q <= sfr_req_i.wdata;
         end
         if (wr_hit(sfr_req_i, TTC_OFS_PRESCALE)) begin
            ps_q <= sfr_req_i.wdata & TTC_PS_MASK; // see RULE11
         end
      end
   end

   // timer 2 count with reload
   assign t2_sum = {t2h_q, t2l_q} + 16'h0001;
   assign ovf2 = (t2m != TTC_T2_OFF) && tick2 && ({t2h_q, t2l_q} == 16'hFFFF);
   assign baud_ovf = ovf2 && (t2m == TTC_T2_BAUD); // see RULE23

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         t2l_q <= TTC_RST_BYTE;
         t2h_q <= TTC_RST_BYTE;
      end else if (wr_t2l || wr_t2h) begin
         if (wr_t2l) begin
            t2l_q <= sfr_req_i.wdata;
         end
         if (wr_t2h) begin
            t2h_q <= sfr_req_i.wdata;
         end
      end else if (ovf2 && t2m != TTC_T2_FREE) begin
         t2l_q <= t2rll_q; // see RULE22 see RULE23
         t2h_q <= t2rlh_q;
      end else if (t2m != TTC_T2_OFF && tick2) begin
         {t2h_q, t2l_q} <= t2_sum;
      end
   end

   // reload pair registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         t2rll_q <= TTC_RST_BYTE;
         t2rlh_q <= TTC_RST_BYTE;
      end else begin
         if (wr_hit(sfr_req_i, TTC_OFS_T2RLL)) begin
            t2rll_q <= sfr_req_i.wdata;
         end
         if (wr_hit(sfr_req_i, TTC_OFS_T2RLH)) begin
            t2rlh_q <= sfr_req_i.wdata;
         end
      end
   end

   // timer 2 control; overflow sets flag only outside baud mode
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         t2ctrl_q <= TTC_RST_BYTE;
      end else begin
         if (wr_t2c) begin
            t2ctrl_q <= sfr_req_i.wdata; // see RULE16 see RULE21
         end
         if (ovf2 && t2m != TTC_T2_BAUD) begin
            t2ctrl_q[TTC_T2_OVF] <= 1'b1; // see RULE15
         end
      end
   end

   // wrap pulses, one clock per overflow
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         t_zero_wrap_output_o <= 1'b0;
         t_one_wrap_output_o <= 1'b0;
      end else begin
         t_zero_wrap_output_o <= ovf0; // see RULE3
         t_one_wrap_output_o <= ovf1;
      end
   end

   // serial shift clocks: timer 2 baud overflow or timer 1 overflow
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rx_shift_clock_o <= 1'b0;
         tx_shift_clock_o <= 1'b0;
      end else begin
         rx_shift_clock_o <= t2ctrl_q[TTC_T2_RXSEL] ? baud_ovf : ovf1; // see RULE17
         tx_shift_clock_o <= t2ctrl_q[TTC_T2_TXSEL] ? baud_ovf : ovf1; // see RULE23
      end
   end

   // interrupt levels from the flags
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         t_zero_irq_o <= 1'b0;
         t_one_irq_o <= 1'b0;
         t_two_irq_o <= 1'b0;
      end else begin
         t_zero_irq_o <= tctrl_q[TTC_TC_T0_FLAG] && !t_zero_isr_ack_i;
         t_one_irq_o <= tctrl_q[TTC_TC_T1_FLAG] && !t_one_isr_ack_i;
         t_two_irq_o <= t2ctrl_q[TTC_T2_OVF] || t2ctrl_q[TTC_T2_EXT]; // see RULE16
      end
   end

   // read data registered one cycle after the read request
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_req_i.rd) begin
         case (sfr_req_i.addr)
            TTC_OFS_TCTRL: sfr_rdata_o <= tctrl_q;
            TTC_OFS_TMODE: sfr_rdata_o <= tmode_q;
            TTC_OFS_T0L: sfr_rdata_o <= t0l_q;
            TTC_OFS_T1L: sfr_rdata_o <= t1l_q;
            TTC_OFS_T0H: sfr_rdata_o <= t0h_q;
            TTC_OFS_T1H: sfr_rdata_o <= t1h_q;
            TTC_OFS_PRESCALE: sfr_rdata_o <= ps_q;
            TTC_OFS_T2CTRL: sfr_rdata_o <= t2ctrl_q;
            TTC_OFS_T2RLL: sfr_rdata_o <= t2rll_q;
            TTC_OFS_T2RLH: sfr_rdata_o <= t2rlh_q;
            TTC_OFS_T2L: sfr_rdata_o <= t2l_q;
            TTC_OFS_T2H: sfr_rdata_o <= t2h_q;
            default: sfr_rdata_o <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: rtl/ttc_pkg.sv */
// package for the three timer/counter unit: register map, fields, types
package ttc_pkg;
   // special-function register offsets
   localparam logic [7:0] TTC_OFS_TCTRL = 8'h88;
   localparam logic [7:0] TTC_OFS_TMODE = 8'h89;
   localparam logic [7:0] TTC_OFS_T0L = 8'h8A;
   localparam logic [7:0] TTC_OFS_T1L = 8'h8B;
   localparam logic [7:0] TTC_OFS_T0H = 8'h8C;
   localparam logic [7:0] TTC_OFS_T1H = 8'h8D;
   localparam logic [7:0] TTC_OFS_PRESCALE = 8'h8E;
   localparam logic [7:0] TTC_OFS_T2CTRL = 8'hC8;
   localparam logic [7:0] TTC_OFS_T2RLL = 8'hCA;
   localparam logic [7:0] TTC_OFS_T2RLH = 8'hCB;
   localparam logic [7:0] TTC_OFS_T2L = 8'hCC;
   localparam logic [7:0] TTC_OFS_T2H = 8'hCD;
   // timer control fields
   localparam int TTC_TC_T1_FLAG = 7;
   localparam int TTC_TC_T1_RUN = 6;
   localparam int TTC_TC_T0_FLAG = 5;
   localparam int TTC_TC_T0_RUN = 4;
   // mode register fields (per timer nibble: gate, counter select, mode[1:0])
   localparam int TTC_MD_T1_BASE = 4;
   localparam int TTC_MD_T0_BASE = 0;
   localparam int TTC_MD_GATE = 3;
   localparam int TTC_MD_CNT = 2;
   // prescale select fields
   localparam int TTC_PS_T2 = 5;
   localparam int TTC_PS_T1 = 4;
   localparam int TTC_PS_T0 = 3;
   localparam logic [7:0] TTC_PS_MASK = 8'h38;
   // timer 2 control fields
   localparam int TTC_T2_OVF = 7;
   localparam int TTC_T2_EXT = 6;
   localparam int TTC_T2_RXSEL = 5;
   localparam int TTC_T2_TXSEL = 4;
   localparam int TTC_T2_RUN = 2;
   localparam int TTC_T2_RLDIS = 0;
   // reset values
   localparam logic [7:0] TTC_RST_BYTE = 8'h00;
   // timing counts
   localparam logic [3:0] TTC_DIV_SLOW = 4'hC;
   localparam logic [3:0] TTC_DIV_FAST = 4'h4;
   localparam logic [3:0] TTC_DIV_BAUD = 4'h2;
   // timer 0/1 modes
   typedef enum logic [1:0] {
      TTC_M13 = 2'h0,
      TTC_M16 = 2'h1,
      TTC_M8R = 2'h2,
      TTC_MSPLIT = 2'h3
   } ttc_mode_t;
   // timer 2 modes
   typedef enum {TTC_T2_OFF, TTC_T2_FREE, TTC_T2_RELOAD, TTC_T2_BAUD} ttc_t2_mode_t;
   // register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ttc_sfr_req_t;
endpackage

/* File: dv/ttc_sva.sv */
// assertion checker for the three timer/counter unit
`timescale 1ns/100ps
`default_nettype none
module ttc_sva
   import ttc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire ttc_sfr_req_t sfr_req_i,
   input wire logic t_zero_isr_ack_i,
   input wire logic t_one_isr_ack_i,
   input wire logic t_zero_wrap_output_o,
   input wire logic t_one_wrap_output_o,
   input wire logic t_zero_irq_o,
   input wire logic t_one_irq_o,
   input wire logic t_two_irq_o,
   input wire logic tx_shift_clock_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic t2_wr;
   logic tx_sel_q;
   assign t2_wr = sfr_req_i.wr && (sfr_req_i.addr == TTC_OFS_T2CTRL);
   // tracks the transmit clock select as written over the bus
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_sel_q <= 1'b0;
      end else if (t2_wr) begin
         tx_sel_q <= sfr_req_i.wdata[TTC_T2_TXSEL];
      end
   end
   AST_T0_WRAP_ONE: assert property (t_zero_wrap_output_o |=> !t_zero_wrap_output_o)
      else $error("timer 0 wrap pulse longer than one clock");
   AST_T1_WRAP_ONE: assert property (t_one_wrap_output_o |=> !t_one_wrap_output_o)
      else $error("timer 1 wrap pulse longer than one clock");
   AST_T0_WRAP_FLAG: assert property (t_zero_wrap_output_o |-> ##[0:1] t_zero_irq_o)
      else $error("timer 0 wrap without flag");
   AST_T0_ACK: assert property ($rose(t_zero_isr_ack_i) |-> ##[1:2] !t_zero_irq_o)
      else $error("timer 0 flag kept after service entry");
   AST_T1_ACK: assert property ($rose(t_one_isr_ack_i) |-> ##[1:2] !t_one_irq_o)
      else $error("timer 1 flag kept after service entry");
   AST_TX_FROM_T1: assert property (!$past(tx_sel_q) && t_one_wrap_output_o
      |-> tx_shift_clock_o)
      else $error("transmit clock missed timer 1 overflow");
   AST_TX_ONE: assert property (tx_shift_clock_o |=> !tx_shift_clock_o)
      else $error("shift clock pulse longer than one clock");
   AST_T2_FORCE: assert property (t2_wr && (sfr_req_i.wdata[TTC_T2_OVF]
      || sfr_req_i.wdata[TTC_T2_EXT]) |-> ##[1:2] t_two_irq_o)
      else $error("timer 2 flag write did not raise interrupt");
   AST_T2_HOLD: assert property (t_two_irq_o && !t2_wr && !$past(t2_wr)
      |=> t_two_irq_o)
      else $error("timer 2 flag dropped without software clear");
endmodule
bind ttc_unit ttc_sva ttc_sva_inst (.clk_i, .sys_rst_i, .sfr_req_i, .t_zero_isr_ack_i,
   .t_one_isr_ack_i, .t_zero_wrap_output_o, .t_one_wrap_output_o, .t_zero_irq_o,
   .t_one_irq_o, .t_two_irq_o, .tx_shift_clock_o);
`default_nettype wire

/* File: dv/ttc_far_side.sv */
// far-side model: external count inputs and gating interrupt lines
`timescale 1ns/100ps
`default_nettype none
module ttc_far_side (
   input wire logic clk_i,
   output logic [1:0] count_o,
   output logic [1:0] gate_n_o
);
   initial begin
      count_o = 2'b11;
      gate_n_o = 2'b11;
   end
   // falling edges on selected lines, kept slower than an eighth of the clock
   task automatic falls(input logic [1:0] sel, input int n);
      repeat (n) begin
         @(posedge clk_i);
         count_o <= ~sel;
         repeat (5) @(posedge clk_i);
         count_o <= 2'b11;
         repeat (4) @(posedge clk_i);
      end
   endtask
   task automatic set_gate(input logic [1:0] v);
      @(posedge clk_i);
      gate_n_o <= v;
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking testbench for the three timer/counter unit
`timescale 1ns/100ps
`default_nettype none
module tb
   import ttc_pkg::*;
;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   ttc_sfr_req_t req = '0;
   logic ack0 = 1'b0, ack1 = 1'b0;
   logic [7:0] rdata;
   logic [1:0] cnt, gate_n;
   logic w0, w1, i0, i1, i2, rxs, txs;
   int fail_count = 0;
   int cmp_count = 0;
   always #10 clk_i = ~clk_i;
   ttc_far_side ttc_far_side_inst (.clk_i(clk_i), .count_o(cnt), .gate_n_o(gate_n));
   ttc_unit ttc_unit_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
      .t_zero_count_input_i(cnt[0]), .t_one_count_input_i(cnt[1]),
      .ext_irq_zero_input_n_i(gate_n[0]), .ext_irq_one_input_n_i(gate_n[1]),
      .t_zero_isr_ack_i(ack0), .t_one_isr_ack_i(ack1), .t_zero_wrap_output_o(w0),
      .t_one_wrap_output_o(w1), .t_zero_irq_o(i0), .t_one_irq_o(i1), .t_two_irq_o(i2),
      .rx_shift_clock_o(rxs), .tx_shift_clock_o(txs)
   );
   task automatic tally_and_finish();
      $display("counts: %0d compared, %0d mismatched", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic chk_cyc(input string nm, input int e, input int g);
      cmp_count++;
      if (g != e) begin
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      req <= '0;
      #1 d = rdata;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return w0;
         1: return w1;
         2: return txs;
         3: return rxs;
         4: return i1;
         default: return i2;
      endcase
   endfunction
   // cycles until the selected event is next seen, bounded
   task automatic wait_for(input int s, output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
         if (n > 400) begin
            $display("timeout waiting on event %0d", s);
            fail_count++;
            tally_and_finish();
         end
      end while (pick(s) !== 1'b1);
   endtask
   task automatic period(input string nm, input int s, input int e);
      int n;
      repeat (3) wait_for(s, n);
      chk_cyc(nm, e, n);
   endtask
   task automatic test_reset();
      logic [7:0] ofs [13] = '{TTC_OFS_TCTRL, TTC_OFS_TMODE, TTC_OFS_T0L, TTC_OFS_T1L,
         TTC_OFS_T0H, TTC_OFS_T1H, TTC_OFS_PRESCALE, TTC_OFS_T2CTRL, TTC_OFS_T2RLL,
         TTC_OFS_T2RLH, TTC_OFS_T2L, TTC_OFS_T2H, 8'h81};
      logic [7:0] d;
      wr(8'h81, 8'hFF);
      foreach (ofs[k]) begin
         rd(ofs[k], d);
         chk_val("value after reset", 16'h0000, {8'h00, d});
      end
      wr(TTC_OFS_PRESCALE, 8'hFF);
      rd(TTC_OFS_PRESCALE, d);
      chk_val("prescale bits", {8'h00, TTC_PS_MASK}, {8'h00, d});
      $display("test_reset done");
   endtask
   task automatic test_mode2();
      ttc_far_side_inst.set_gate(2'b00);
      wr(TTC_OFS_PRESCALE, 8'h00);
      wr(TTC_OFS_TMODE, 8'h02);
      wr(TTC_OFS_T0H, 8'hFF);
      wr(TTC_OFS_T0L, 8'hFF);
      wr(TTC_OFS_TCTRL, 8'h10);
      period("t0 reload slow", 0, 12);
      wr(TTC_OFS_PRESCALE, 8'h08);
      period("t0 reload fast", 0, 4);
      chk_val("t0 irq", 16'h0001, {15'h0000, i0});
      wr(TTC_OFS_TCTRL, 8'h00);
      ttc_far_side_inst.set_gate(2'b11);
      $display("test_mode2 done");
   endtask
   task automatic test_wrap();
      logic [7:0] lo [2] = '{8'h1F, 8'hFF};
      logic [7:0] d;
      int n;
      for (int m = 0; m < 2; m++) begin
         wr(TTC_OFS_TMODE, 8'(m));
         wr(TTC_OFS_T0H, 8'hFF);
         wr(TTC_OFS_T0L, lo[m]);
         wr(TTC_OFS_TCTRL, 8'h10);
         wait_for(0, n);
         wr(TTC_OFS_TCTRL, 8'h00);
         rd(TTC_OFS_T0H, d);
         chk_val("t0 high after wrap", 16'h0000, {8'h00, d});
         rd(TTC_OFS_T0L, d);
         chk_val("t0 low after wrap", 16'h0000, {8'h00, d & lo[m]});
      end
      $display("test_wrap done");
   endtask
   task automatic check_counts(input string nm, input logic [7:0] e);
      logic [7:0] a, b;
      rd(TTC_OFS_T0L, a);
      rd(TTC_OFS_T1L, b);
      chk_val(nm, {e, e}, {a, b});
   endtask
   task automatic test_counter();
      wr(TTC_OFS_TMODE, 8'hEE);
      wr(TTC_OFS_T0H, 8'h00);
      wr(TTC_OFS_T1H, 8'h00);
      wr(TTC_OFS_T0L, 8'h00);
      wr(TTC_OFS_T1L, 8'h00);
      wr(TTC_OFS_TCTRL, 8'h50);
      ttc_far_side_inst.falls(2'b11, 5);
      check_counts("external counts", 8'h05);
      ttc_far_side_inst.set_gate(2'b00);
      ttc_far_side_inst.falls(2'b11, 3);
      ttc_far_side_inst.set_gate(2'b11);
      check_counts("gated counts", 8'h05);
      wr(TTC_OFS_TCTRL, 8'h00);
      $display("test_counter done");
   endtask
   task automatic test_split();
      logic [7:0] d;
      int n;
      wr(TTC_OFS_TMODE, 8'h03);
      wr(TTC_OFS_T0L, 8'hFF);
      wr(TTC_OFS_T0H, 8'hFF);
      wr(TTC_OFS_TCTRL, 8'h50);
      wait_for(0, n);
      wait_for(4, n);
      wr(TTC_OFS_TMODE, 8'h33);
      wr(TTC_OFS_T1L, 8'h55);
      repeat (30) @(posedge clk_i);
      rd(TTC_OFS_T1L, d);
      chk_val("t1 held", 16'h0055, {8'h00, d});
      wr(TTC_OFS_TMODE, 8'h23);
      wr(TTC_OFS_T1H, 8'hFF);
      wr(TTC_OFS_T1L, 8'hFF);
      period("t1 beside split", 1, 12);
      wr(TTC_OFS_TMODE, 8'h33);
      wr(TTC_OFS_TCTRL, 8'hA0);
      chk_val("flags before ack", 16'h0003, {14'h0000, i1, i0});
      @(posedge clk_i);
      ack0 <= 1'b1;
      ack1 <= 1'b1;
      @(posedge clk_i);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_val("flags after ack", 16'h0000, {14'h0000, i1, i0});
      $display("test_split done");
   endtask
   task automatic test_t2();
      logic [7:0] ps [2] = '{8'h00, 8'h20};
      int sp [2] = '{48, 40};
      logic [7:0] a, b;
      int n;
      foreach (ps[k]) begin
         wr(TTC_OFS_PRESCALE, ps[k]);
         wr(TTC_OFS_T2CTRL, 8'h05);
         rd(TTC_OFS_T2L, a);
         repeat (sp[k] - 2) @(posedge clk_i);
         rd(TTC_OFS_T2L, b);
         chk_val("t2 rate", (k == 0) ? 16'h0004 : 16'h000A, {8'h00, b - a});
         wr(TTC_OFS_T2CTRL, 8'h00);
      end
      for (int m = 0; m < 2; m++) begin
         wr(TTC_OFS_T2RLH, 8'hF0);
         wr(TTC_OFS_T2L, 8'hFF);
         wr(TTC_OFS_T2H, 8'hFF);
         wr(TTC_OFS_T2CTRL, (m == 0) ? 8'h05 : 8'h04);
         wait_for(5, n);
         rd(TTC_OFS_T2H, a);
         chk_val("t2 high after wrap", (m == 0) ? 16'h0000 : 16'h00F0,
            {8'h00, a});
         wr(TTC_OFS_T2CTRL, 8'h00);
      end
      wr(TTC_OFS_T2RLL, 8'hFF);
      wr(TTC_OFS_T2L, 8'hFF);
      wr(TTC_OFS_T2H, 8'hFF);
      wr(TTC_OFS_T2RLH, 8'hFF);
      wr(TTC_OFS_T2CTRL, 8'h14);
      period("t2 baud tx", 2, 2);
      chk_val("t2 irq in baud", 16'h0000, {15'h0000, i2});
      wr(TTC_OFS_T2CTRL, 8'h34);
      period("t2 baud rx", 3, 2);
      for (int m = 0; m < 2; m++) begin
         wr(TTC_OFS_T2CTRL, (m == 0) ? 8'h80 : 8'h40);
         repeat (2) @(posedge clk_i);
         chk_val("t2 forced irq", 16'h0001, {15'h0000, i2});
         wr(TTC_OFS_T2CTRL, 8'h00);
         repeat (2) @(posedge clk_i);
         chk_val("t2 cleared irq", 16'h0000, {15'h0000, i2});
      end
      $display("test_t2 done");
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      test_reset();
      test_mode2();
      test_wrap();
      test_counter();
      test_split();
      test_t2();
      tally_and_finish();
   end
endmodule
`default_nettype wire
